// ### rtl/fhs_host_status.sv
// Overview of operation
// RQ1 - Host polls main status before each non-DMA data byte.
// RQ2 - Request flag high only when a data byte may move.
// RQ3 - Direction flag: 1 host reads, 0 host writes.
// RQ4 - PIO mode flag mirrors non-DMA selection from timing setup.
// RQ5 - Busy flag high during command, low after result phase ends.
// RQ6 - Drive busy bits high while that drive seeks.
// RQ7 - Data register is 8 bits, stack-backed, one entry per access.
// RQ8 - Disk input bit 7 is inverse of active-low change pin.
// RQ9 - Disk input bits 6 to 0 are not driven on read.
// RQ10 - Write at 07h picks data rate; reduce-write low only at 500K.
// RQ11 - Four result status bytes; status-1 bits 6 and 3 read zero. Only status-0 and status-1 are built here.
// RQ12 - Status-0 bits 7:6 hold the completion code.
// RQ13 - Status-0 bit 5 marks completed positioning commands.
// RQ14 - Status-0 bit 4 flags equipment fault on track-zero problems.
// RQ15 - Status-0 holds not-ready, head and drive select bits.
// RQ16 - Status-1 bit 7 flags access past the last sector.
// RQ17 - Status-1 bit 5 flags ID or data CRC error.
// RQ18 - Status-1 bit 4 flags overrun or underrun.
// RQ19 - Status-1 bit 2 flags missing sector cases.
// RQ20 - Status-1 bit 1 flags write to protected diskette.
// RQ21 - Status-1 bit 0 flags missing address mark.
// RQ22 - Request flag drops after each command byte, rises when next needed.
// RQ23 - Reserved main status bits 3 and 2 read zero.

`timescale 1ns/1ns
`include "fhs_cfg.svh"
module fhs_host_status (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,

    // Host register port
    input  wire logic [2:0] host_addr,
    input  wire logic       host_rd,
    input  wire logic       host_wr,
    input  wire logic [7:0] host_wdata,
    output logic      [7:0] host_rdata,
    output logic      [7:0] host_rdata_oe,

    // Core sequencing
    input  wire logic       core_cmd_start,
    input  wire logic       core_param_need,
    input  wire logic       core_cmd_done,
    input  wire logic       core_result_push,
    input  wire logic [7:0] core_result_byte,
    input  wire logic       core_result_latch,
    input  wire logic       pio_select,
    input  wire logic       seek_drive_a,
    input  wire logic       seek_drive_b,
    output logic            core_cmd_valid,
    output logic      [7:0] core_cmd_byte,

    // Result status sources and latched bytes
    input  wire logic [1:0] completion_code,
    input  wire logic       positioning_done,
    input  wire logic       recal_no_track0,
    input  wire logic       step_past_zero,
    input  wire logic       drive_not_ready,
    input  wire logic       head_address,
    input  wire logic       first_drive_selected,
    input  wire logic       second_drive_selected,
    input  wire logic       past_last_sector,
    input  wire logic       ended_without_tc,
    input  wire logic       id_crc_fault,
    input  wire logic       data_crc_fault,
    input  wire logic       service_late,
    input  wire logic       sector_not_found,
    input  wire logic       id_read_fault,
    input  wire logic       start_sector_absent,
    input  wire logic       write_on_protected,
    input  wire logic       data_mark_absent,
    input  wire logic       id_absent_two_index,
    output logic      [7:0] result_status_zero,
    output logic      [7:0] result_status_one,

    // Drive side
    input  wire logic       media_changed_n,
    output logic      [1:0] rate_select,
    output logic            reduce_write
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fhs_pkg::fhs_phase_t             phase_q;
    logic                            req_q;
    logic                            pio_q;
    logic                            seek_a_q;
    logic                            seek_b_q;
    logic [7:0]                      stack_mem [`FHS_STACK_DEPTH];
    logic [`FHS_STACK_AW-1:0]        wr_ptr_q;
    logic [`FHS_STACK_AW-1:0]        rd_ptr_q;
    logic [`FHS_STACK_AW:0]          count_q;
    logic [7:0]                      sz_w;
    logic [7:0]                      so_w;

    function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    wire logic data_rd = host_rd & hit(host_addr, `FHS_OFS_DATA_STACK) & req_q
                       & (phase_q == fhs_pkg::FHS_RESULT);
    wire logic data_wr = host_wr & hit(host_addr, `FHS_OFS_DATA_STACK) & req_q
                       & (phase_q != fhs_pkg::FHS_RESULT);
    // Pushes into a full stack are dropped
    wire logic push    = core_result_push & (count_q != 5'(`FHS_STACK_DEPTH));

    // ------------------------------------------------------------
    // Controller phase
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q <= fhs_pkg::FHS_IDLE;
        end else begin
            unique case (phase_q)
                fhs_pkg::FHS_IDLE: begin
                    if (data_wr) begin
                        phase_q <= fhs_pkg::FHS_COMMAND;
                    end
                end
                fhs_pkg::FHS_COMMAND: begin
                    if (core_cmd_start) begin
                        phase_q <= fhs_pkg::FHS_EXECUTE;
                    end
                end
                fhs_pkg::FHS_EXECUTE: begin
                    if (core_cmd_done) begin
                        // An empty result set goes straight back to idle
                        if (count_q != '0 || push) begin
                            phase_q <= fhs_pkg::FHS_RESULT;
                        end else begin
                            phase_q <= fhs_pkg::FHS_IDLE;
                        end
                    end
                end
                fhs_pkg::FHS_RESULT: begin
                    if (data_rd && count_q == 5'h01 && !push) begin
                        phase_q <= fhs_pkg::FHS_IDLE;     // see RQ5
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Host request flag
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            req_q <= 1'b1;
        end else if (phase_q == fhs_pkg::FHS_COMMAND && core_param_need) begin
            // A new request wins over a byte taken in the same cycle
            req_q <= 1'b1;                                // see RQ22
        end else if (data_wr) begin
            req_q <= 1'b0;                                // see RQ22
        end else if (phase_q == fhs_pkg::FHS_EXECUTE) begin
            req_q <= 1'b0;                                // see RQ2
        end else if (phase_q == fhs_pkg::FHS_RESULT) begin
            req_q <= (count_q > 5'h01)
                  || (count_q == 5'h01 && !data_rd)
                  || push;                                // see RQ2
        end else if (phase_q == fhs_pkg::FHS_IDLE) begin
            req_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Mode and seek mirrors
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pio_q    <= 1'b0;
            seek_a_q <= 1'b0;
            seek_b_q <= 1'b0;
        end else begin
            pio_q    <= pio_select;                       // see RQ4
            seek_a_q <= seek_drive_a;                     // see RQ6
            seek_b_q <= seek_drive_b;                     // see RQ6
        end
    end

    // ------------------------------------------------------------
    // Result stack
    // ------------------------------------------------------------
    // Result bytes wait here until the host reads them
    always_ff @(posedge mclk) begin
        if (push) begin
            stack_mem[wr_ptr_q] <= core_result_byte;      // see RQ7
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (data_rd && count_q != '0) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;              // see RQ7
            end
            count_q <= count_q + {4'h0, push} - {4'h0, data_rd && count_q != '0};
        end
    end

    // ------------------------------------------------------------
    // Command byte hand-off
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            core_cmd_valid <= 1'b0;
            core_cmd_byte  <= 8'h00;
        end else begin
            core_cmd_valid <= data_wr;                    // see RQ7
            if (data_wr) begin
                core_cmd_byte <= host_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Rate control
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rate_select  <= `FHS_RATE_RESET;
            reduce_write <= 1'b0;
        end else if (host_wr && hit(host_addr, `FHS_OFS_DISK_INPUT)) begin
            rate_select  <= host_wdata[1:0];              // see RQ10
            reduce_write <= (host_wdata[1:0] != fhs_pkg::FHS_RATE_500K); // see RQ10
        end
    end

    // ------------------------------------------------------------
    // Result status bytes
    // ------------------------------------------------------------
    fhs_result_pack u_pack (
        .completion_code       (completion_code),
        .positioning_done      (positioning_done),
        .recal_no_track0       (recal_no_track0),
        .step_past_zero        (step_past_zero),
        .drive_not_ready       (drive_not_ready),
        .head_address          (head_address),
        .first_drive_selected  (first_drive_selected),
        .second_drive_selected (second_drive_selected),
        .past_last_sector      (past_last_sector),
        .ended_without_tc      (ended_without_tc),
        .id_crc_fault          (id_crc_fault),
        .data_crc_fault        (data_crc_fault),
        .service_late          (service_late),
        .sector_not_found      (sector_not_found),
        .id_read_fault         (id_read_fault),
        .start_sector_absent   (start_sector_absent),
        .write_on_protected    (write_on_protected),
        .data_mark_absent      (data_mark_absent),
        .id_absent_two_index   (id_absent_two_index),
        .status_zero           (sz_w),
        .status_one            (so_w)
    );

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            result_status_zero <= 8'h00;
            result_status_one  <= 8'h00;
        end else if (core_result_latch) begin
            result_status_zero <= sz_w;                   // see RQ11
            result_status_one  <= so_w;                   // see RQ11
        end
    end

    // ------------------------------------------------------------
    // Host read data, registered
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            host_rdata    <= 8'h00;
            host_rdata_oe <= 8'h00;
        end else begin
            host_rdata    <= 8'h00;
            host_rdata_oe <= 8'h00;
            if (host_rd) begin
                if (hit(host_addr, `FHS_OFS_MAIN_STATUS)) begin
                    // Direction follows the phase: only results flow to the host
                    host_rdata[`FHS_MS_REQ]   <= req_q;                                  // see RQ2
                    host_rdata[`FHS_MS_DIR]   <= (phase_q == fhs_pkg::FHS_RESULT);       // see RQ3
                    host_rdata[`FHS_MS_PIO]   <= pio_q;                                  // see RQ4
                    host_rdata[`FHS_MS_BUSY]  <= (phase_q != fhs_pkg::FHS_IDLE);         // see RQ5
                    host_rdata[`FHS_MS_DRV_B] <= seek_b_q;                               // see RQ6
                    host_rdata[`FHS_MS_DRV_A] <= seek_a_q;                               // see RQ6
                    host_rdata_oe             <= 8'hFF;                                  // see RQ23
                end else if (hit(host_addr, `FHS_OFS_DATA_STACK)) begin
                    host_rdata    <= (count_q != '0) ? stack_mem[rd_ptr_q] : 8'h00;      // see RQ7
                    host_rdata_oe <= 8'hFF;
                end else if (hit(host_addr, `FHS_OFS_DISK_INPUT)) begin
                    // Bits 6 to 0 stay undriven on a disk input read
                    host_rdata[`FHS_DI_CHANGED]    <= ~media_changed_n;                  // see RQ8
                    host_rdata_oe[`FHS_DI_CHANGED] <= 1'b1;                              // see RQ9
                end
            end
        end
    end
endmodule : fhs_host_status

// ### rtl/fhs_cfg.svh
`ifndef FHS_CFG_SVH
`define FHS_CFG_SVH
// ------------------------------------------------------------
// Register offsets (base-relative)
// ------------------------------------------------------------
`define FHS_OFS_MAIN_STATUS   3'h4
`define FHS_OFS_DATA_STACK    3'h5
`define FHS_OFS_DISK_INPUT    3'h7
// ------------------------------------------------------------
// Main status and disk input field positions
// ------------------------------------------------------------
`define FHS_MS_REQ            7
`define FHS_MS_DIR            6
`define FHS_MS_PIO            5
`define FHS_MS_BUSY           4
`define FHS_MS_DRV_B          1
`define FHS_MS_DRV_A          0
`define FHS_DI_CHANGED        7
// ------------------------------------------------------------
// Reset values and sizes
// ------------------------------------------------------------
`define FHS_RATE_RESET        2'h0
`define FHS_STACK_DEPTH       16
`define FHS_STACK_AW          4
`endif

// ### rtl/fhs_pkg.sv
package fhs_pkg;
    typedef enum logic [1:0] {
        FHS_IDLE    = 2'b00,
        FHS_COMMAND = 2'b01,
        FHS_EXECUTE = 2'b10,
        FHS_RESULT  = 2'b11
    } fhs_phase_t;

    typedef enum logic [1:0] {
        FHS_RATE_500K = 2'b00,
        FHS_RATE_250K = 2'b10,
        FHS_RATE_300K = 2'b01,
        FHS_RATE_1M   = 2'b11
    } fhs_rate_t;

    typedef enum logic [1:0] {
        FHS_CC_NORMAL  = 2'b00,
        FHS_CC_FAILED  = 2'b01,
        FHS_CC_INVALID = 2'b10,
        FHS_CC_POLLED  = 2'b11
    } fhs_code_t;
endpackage : fhs_pkg

// ### rtl/fhs_result_pack.sv
`timescale 1ns/1ns
`include "fhs_cfg.svh"
module fhs_result_pack (
    // Completion
    input  wire logic [1:0] completion_code,
    input  wire logic       positioning_done,
    input  wire logic       recal_no_track0,
    input  wire logic       step_past_zero,
    input  wire logic       drive_not_ready,
    input  wire logic       head_address,
    input  wire logic       first_drive_selected,
    input  wire logic       second_drive_selected,
    // Transfer faults
    input  wire logic       past_last_sector,
    input  wire logic       ended_without_tc,
    input  wire logic       id_crc_fault,
    input  wire logic       data_crc_fault,
    input  wire logic       service_late,
    input  wire logic       sector_not_found,
    input  wire logic       id_read_fault,
    input  wire logic       start_sector_absent,
    input  wire logic       write_on_protected,
    input  wire logic       data_mark_absent,
    input  wire logic       id_absent_two_index,
    // Packed bytes
    output logic      [7:0] status_zero,
    output logic      [7:0] status_one
);
    always_comb begin
        status_zero[7:6] = completion_code;                        // see RQ12
        status_zero[5]   = positioning_done;                       // see RQ13
        status_zero[4]   = recal_no_track0 | step_past_zero;       // see RQ14
        status_zero[3]   = drive_not_ready;                        // see RQ15
        status_zero[2]   = head_address;                           // see RQ15
        status_zero[1]   = second_drive_selected;                  // see RQ15
        status_zero[0]   = first_drive_selected;                   // see RQ15
        status_one[7]    = past_last_sector | ended_without_tc;    // see RQ16
        status_one[6]    = 1'b0;                                   // see RQ11
        status_one[5]    = id_crc_fault | data_crc_fault;          // see RQ17
        status_one[4]    = service_late;                           // see RQ18
        status_one[3]    = 1'b0;                                   // see RQ11
        status_one[2]    = sector_not_found | id_read_fault | start_sector_absent; // see RQ19
        status_one[1]    = write_on_protected;                     // see RQ20
        status_one[0]    = data_mark_absent | id_absent_two_index; // see RQ21
    end
endmodule : fhs_result_pack

// ### verif/fhs_host_status_assertions.sv
`timescale 1ns/1ns
module fhs_host_status_assertions (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       arst_n,
    // Host register port
    input wire logic [2:0] host_addr,
    input wire logic       host_rd,
    input wire logic       host_wr,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    input wire logic [7:0] host_rdata_oe,
    // Core and status side
    input wire logic       pio_select,
    input wire logic       seek_drive_a,
    input wire logic       seek_drive_b,
    input wire logic       core_cmd_valid,
    input wire logic [7:0] core_cmd_byte,
    input wire logic       core_result_latch,
    input wire logic [1:0] completion_code,
    input wire logic       positioning_done,
    input wire logic [7:0] result_status_zero,
    input wire logic [7:0] result_status_one,
    // Drive side
    input wire logic       media_changed_n,
    input wire logic [1:0] rate_select,
    input wire logic       reduce_write
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    AST_RESERVED_ZERO: assert property (
        host_rd && host_addr == 3'h4 |=> host_rdata[3:2] == 2'h0 && host_rdata_oe == 8'hFF)
        else $error("reserved status bits not zero");
    AST_DISK_INPUT: assert property (
        host_rd && host_addr == 3'h7 |=> host_rdata_oe == 8'h80 && host_rdata[7] == !$past(media_changed_n))
        else $error("disk input read wrong");
    AST_QUIET_BUS: assert property (
        !host_rd |=> host_rdata == 8'h00 && host_rdata_oe == 8'h00)
        else $error("read bus driven without read");
    AST_MODE_MIRROR: assert property (
        $past(arst_n) && host_rd && host_addr == 3'h4 && $stable({pio_select, seek_drive_b, seek_drive_a})
        |=> {host_rdata[5], host_rdata[1:0]} == $past({pio_select, seek_drive_b, seek_drive_a}))
        else $error("mode or seek bits wrong");
    AST_RATE_LOAD: assert property (
        host_wr && host_addr == 3'h7 |=> rate_select == $past(host_wdata[1:0]))
        else $error("rate not loaded");
    AST_RATE_HOLD: assert property (
        !(host_wr && host_addr == 3'h7) |=> $stable(rate_select))
        else $error("rate changed without write");
    AST_REDUCE_WRITE: assert property (
        reduce_write == (rate_select != 2'h0))
        else $error("reduce write wrong");
    AST_CMD_BYTE: assert property (
        core_cmd_valid |-> $past(host_wr) && $past(host_addr) == 3'h5 && core_cmd_byte == $past(host_wdata))
        else $error("command byte without data write");
    AST_S1_ZERO: assert property (
        result_status_one[6] == 1'b0 && result_status_one[3] == 1'b0)
        else $error("unused status one bits set");
    AST_LATCH_S0: assert property (
        core_result_latch |=> result_status_zero[7:5] == $past({completion_code, positioning_done}))
        else $error("status zero not latched");
    AST_STATUS_HOLD: assert property (
        !core_result_latch |=> $stable(result_status_zero) && $stable(result_status_one))
        else $error("status changed without latch");
endmodule : fhs_host_status_assertions

bind fhs_host_status fhs_host_status_assertions u_chk (
    .mclk(mclk), .arst_n(arst_n), .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe), .pio_select(pio_select),
    .seek_drive_a(seek_drive_a), .seek_drive_b(seek_drive_b), .core_cmd_valid(core_cmd_valid),
    .core_cmd_byte(core_cmd_byte), .core_result_latch(core_result_latch), .completion_code(completion_code),
    .positioning_done(positioning_done), .result_status_zero(result_status_zero),
    .result_status_one(result_status_one), .media_changed_n(media_changed_n), .rate_select(rate_select),
    .reduce_write(reduce_write));

// ### verif/fhs_host_model.sv
`timescale 1ns/1ns
module fhs_host_model (
    // Clock
    input  wire logic       mclk,
    // Host register port
    output logic      [2:0] host_addr,
    output logic            host_rd,
    output logic            host_wr,
    output logic      [7:0] host_wdata,
    input  wire logic [7:0] host_rdata
);
    initial begin
        host_addr  = 3'h0;
        host_rd    = 1'b0;
        host_wr    = 1'b0;
        host_wdata = 8'h00;
    end

    // One strobe cycle moves exactly one byte
    task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk) #2;
        host_addr  = a;
        host_wr    = wr;
        host_rd    = !wr;
        host_wdata = d;
        @(posedge mclk) #2;
        host_rd    = 1'b0;
        host_wr    = 1'b0;
        host_wdata = ~d;
        q          = host_rdata;
    endtask : access

    // Polls main status until the byte may move in the wanted direction
    task automatic data_xfer(input logic wr, input logic [7:0] d, output logic [7:0] q, output logic ok);
        logic [7:0] st;
        ok = 1'b0;
        for (int i = 0; i < 16 && !ok; i++) begin
            access(1'b0, 3'h4, 8'h00, st);
            ok = st[7] === 1'b1 && st[6] === !wr;
        end
        if (ok) access(wr, 3'h5, d, q);
    endtask : data_xfer
endmodule : fhs_host_model

// ### verif/fhs_host_status_bench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module fhs_host_status_bench;
    logic        mclk = 1'b0, arst_n = 1'b0, host_rd, host_wr, cmd_valid, reduce, ok;
    logic        pio = 1'b0, sa = 1'b0, sb = 1'b0, chg_n = 1'b1;
    logic [2:0]  host_addr;
    logic [1:0]  rate;
    logic [4:0]  cp = 5'h00;
    logic [19:0] src = 20'h0;
    logic [7:0]  host_wdata, host_rdata, host_rdata_oe, cmd_byte, rb = 8'h00, s0, s1, q;
    logic [7:0]  res [3];
    int          mismatches = 0, n_compared = 0, cycles = 0, seed;

    fhs_host_model host (.mclk(mclk), .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
        .host_wdata(host_wdata), .host_rdata(host_rdata));
    fhs_host_status dut (.mclk(mclk), .arst_n(arst_n), .host_addr(host_addr), .host_rd(host_rd),
        .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
        .core_cmd_start(cp[0]), .core_param_need(cp[1]), .core_cmd_done(cp[2]), .core_result_push(cp[3]),
        .core_result_byte(rb), .core_result_latch(cp[4]), .pio_select(pio), .seek_drive_a(sa),
        .seek_drive_b(sb), .core_cmd_valid(cmd_valid), .core_cmd_byte(cmd_byte),
        .completion_code(src[1:0]), .positioning_done(src[2]), .recal_no_track0(src[3]),
        .step_past_zero(src[4]), .drive_not_ready(src[5]), .head_address(src[6]),
        .first_drive_selected(src[7]), .second_drive_selected(src[8]), .past_last_sector(src[9]),
        .ended_without_tc(src[10]), .id_crc_fault(src[11]), .data_crc_fault(src[12]), .service_late(src[13]),
        .sector_not_found(src[14]), .id_read_fault(src[15]), .start_sector_absent(src[16]),
        .write_on_protected(src[17]), .data_mark_absent(src[18]), .id_absent_two_index(src[19]),
        .result_status_zero(s0), .result_status_one(s1), .media_changed_n(chg_n), .rate_select(rate),
        .reduce_write(reduce));

    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    function automatic logic [7:0] exp_s0(input logic [19:0] s);
        return {s[1:0], s[2], s[3] | s[4], s[5], s[6], s[8], s[7]};
    endfunction : exp_s0
    function automatic logic [7:0] exp_s1(input logic [19:0] s);
        return {s[9] | s[10], 1'b0, s[11] | s[12], s[13], 1'b0, s[14] | s[15] | s[16], s[17], s[18] | s[19]};
    endfunction : exp_s1

    task automatic pulse(input int idx);
        @(posedge mclk) #2;
        cp[idx] = 1'b1;
        @(posedge mclk) #2;
        cp = 5'h00;
    endtask : pulse

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        seed = $urandom(7843);
        repeat (3) @(posedge mclk);
        #2 arst_n = 1'b1;
        // ------------------------------------------------------------
        // Idle status, reserved bits, disk input
        // ------------------------------------------------------------
        host.access(1'b1, 3'h4, 8'hFF, q);
        host.access(1'b0, 3'h4, 8'h00, q);
        `CHK(q, 8'h80)
        for (int i = 0; i < 6; i++) begin
            chg_n = 1'($urandom);
            host.access(1'b0, 3'h7, 8'h00, q);
            `CHK(q[7], ~chg_n)
        end
        $display("test idle status done");
        // ------------------------------------------------------------
        // Data rate codes
        // ------------------------------------------------------------
        for (int i = 0; i < 4; i++) begin
            host.access(1'b1, 3'h7, {6'($urandom), 2'(i)}, q);
            `CHK(rate, 2'(i))
            `CHK(reduce, i != 0)
        end
        $display("test rate select done");
        // ------------------------------------------------------------
        // Command, execution and result walk
        // ------------------------------------------------------------
        rb = 8'($urandom);
        host.data_xfer(1'b1, rb, q, ok);
        `CHK(ok, 1'b1)
        `CHK(cmd_valid, 1'b1)
        `CHK(cmd_byte, rb)
        host.access(1'b0, 3'h4, 8'h00, q);
        `CHK(q, 8'h10)
        pulse(1);
        host.access(1'b0, 3'h4, 8'h00, q);
        `CHK(q, 8'h90)
        host.data_xfer(1'b1, 8'h5A, q, ok);
        `CHK(cmd_byte, 8'h5A)
        pulse(0);
        host.access(1'b0, 3'h4, 8'h00, q);
        `CHK(q, 8'h10)
        for (int i = 0; i < 3; i++) begin
            res[i] = 8'($urandom);
            rb = res[i];
            pulse(3);
        end
        pulse(2);
        host.access(1'b0, 3'h4, 8'h00, q);
        `CHK(q, 8'hD0)
        host.access(1'b1, 3'h5, 8'hA5, q);
        `CHK(cmd_valid, 1'b0)
        for (int i = 0; i < 3; i++) begin
            host.data_xfer(1'b0, 8'h00, q, ok);
            `CHK(q, res[i])
        end
        host.access(1'b0, 3'h4, 8'h00, q);
        `CHK(q, 8'h80)
        $display("test command walk done");
        // ------------------------------------------------------------
        // Result status packing
        // ------------------------------------------------------------
        for (int i = 0; i < 10; i++) begin
            src = (i == 0) ? 20'hFFFFF : (i == 1) ? 20'h00000 : 20'($urandom);
            pulse(4);
            `CHK(s0, exp_s0(src))
            `CHK(s1, exp_s1(src))
        end
        $display("test result status done");
        // ------------------------------------------------------------
        // Mode and seek mirrors
        // ------------------------------------------------------------
        for (int i = 0; i < 5; i++) begin
            {pio, sb, sa} = (i == 0) ? 3'h7 : 3'($urandom);
            repeat (2) @(posedge mclk);
            host.access(1'b0, 3'h4, 8'h00, q);
            `CHK(q, {2'h2, pio, 3'h0, sb, sa})
        end
        $display("test mode mirror done");
        complete_run();
    end
endmodule : fhs_host_status_bench
